// File: hw/ubf_serial_port.sv
// serial port core: registers, baud timing, frame transmit and receive
// assumes a plain register port and pins synchronous to mclk
`timescale 1ns/1ns
`include "ubf_cfg.svh"
module ubf_serial_port
   import ubf_pkg::*;
#(
   parameter int DIV_W = 8
)(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_b,
   // register port
   input  wire logic [`UBF_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   // serial pins
   output logic                       tx_out,
   output logic                       tx_oe,
   input  wire logic                  rx_in,
   output logic                       rx_sel
);
   if (DIV_W != 8) $error("ubf_serial_port: divisor must be 8 bits");

   logic [7:0]    ctrl_a_q;
   logic [7:0]    ctrl_b_q;
   logic [7:0]    div_q;
   logic [8:0]    txbuf_q;
   logic          txbuf_full_q;
   logic [8:0]    rxbuf_q;
   logic          receive_available_flag_q, overrun_error_q, framing_error_q, parity_error_q, nf_q;
   logic          transmit_idle_q, receive_idle_q;
   logic          ovs_tick, voted, noisy;
   logic          unit_en, tx_act, rx_act;
   logic          wlen9, par_en, par_odd, stop2, addr_en;
   logic [3:0]    nbits;
   ubf_tx_state_t tx_st_q;
   ubf_rx_state_t rx_st_q;
   logic [3:0]    tx_ph_q, rx_ph_q;
   logic [3:0]    tx_bit_q, rx_bit_q;
   logic [8:0]    tx_sh_q, rx_sh_q;
   logic          tx_stop_n_q, rx_noise_q;
   logic          tx_line_q;
   logic          rx_done;
   logic          rx_par_bad;
   logic          rx_keep;

   assign unit_en = ctrl_a_q[`UBF_A_EN];
   assign tx_act  = unit_en && ctrl_b_q[`UBF_B_TRANSMIT_ENABLE];
   assign rx_act  = unit_en && ctrl_b_q[`UBF_B_RECEIVE_ENABLE];
   // one format shared by both directions
   assign wlen9   = ctrl_a_q[`UBF_A_WLEN];
   assign par_en  = ctrl_a_q[`UBF_A_PAREN];
   assign par_odd = ctrl_a_q[`UBF_A_PARODD];
   assign stop2   = ctrl_a_q[`UBF_A_STOP2];
   assign addr_en = ctrl_b_q[`UBF_B_ADDEN];
   assign nbits   = wlen9 ? 4'h9 : 4'h8;

   // parity over the payload bits below the top slot
   function automatic logic par_of(input logic [8:0] d, input logic w9, input logic odd);
      logic p;
      p = w9 ? ^d[7:0] : ^d[6:0];
      return p ^ odd;
   endfunction

   // shared rate generator, held in reset while the port is off
   ubf_baud_gen #(.DIV_W(DIV_W)) u_baud (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .clear      (!unit_en),
      .divisor    (div_q),
      .speed_sel  (ctrl_b_q[`UBF_B_SPEED]),
      .ovs_tick   (ovs_tick),
      .timer_tick ()
   );

   ubf_rx_vote u_vote (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .ovs_tick (ovs_tick),
      .rx_pin   (rx_in),
      .voted    (voted),
      .noisy    (noisy)
   );

   // control a: disable clears only break send; enable, format kept
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         ctrl_a_q <= `UBF_CTRL_A_RST;
      else if (reg_wr && reg_addr == `UBF_OFS_CTRL_A)
      begin
         ctrl_a_q             <= reg_wdata;
         ctrl_a_q[`UBF_A_BRK] <= reg_wdata[`UBF_A_BRK] && reg_wdata[`UBF_A_EN];
      end
      else if (!unit_en)
         ctrl_a_q[`UBF_A_BRK] <= 1'b0;

   // control b: transmit/receive enables fall while the unit is off
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         ctrl_b_q <= `UBF_CTRL_B_RST;
      else
      begin
         if (reg_wr && reg_addr == `UBF_OFS_CTRL_B)
            ctrl_b_q <= reg_wdata;
         // enables drop with the disabling write itself, so a readback never lags
         if (!unit_en || (reg_wr && reg_addr == `UBF_OFS_CTRL_A && !reg_wdata[`UBF_A_EN]))
         begin
            ctrl_b_q[`UBF_B_TRANSMIT_ENABLE] <= 1'b0;
            ctrl_b_q[`UBF_B_RECEIVE_ENABLE] <= 1'b0;
         end
      end

   // divisor untouched by disable so re-enable resumes the same rate
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         div_q <= `UBF_DIV_RST;
      else if (reg_wr && reg_addr == `UBF_OFS_DIV)
         div_q <= reg_wdata;

   // transmit holding buffer; emptied whenever the unit is off
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         txbuf_q      <= 9'h000;
         txbuf_full_q <= 1'b0;
      end
      else if (!unit_en)
         txbuf_full_q <= 1'b0;
      else if (reg_wr && reg_addr == `UBF_OFS_TXDATA && !txbuf_full_q)
      begin
         txbuf_q      <= {ctrl_a_q[`UBF_A_TX8], reg_wdata};
         txbuf_full_q <= 1'b1;
      end
      else if (tx_st_q == UBF_TX_IDLE && tx_act && ovs_tick)
         txbuf_full_q <= 1'b0;

   // transmit frame sequencer; stop_count_sel at once when disabled
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         tx_st_q     <= UBF_TX_IDLE;
         tx_ph_q     <= 4'h0;
         tx_bit_q    <= 4'h0;
         tx_sh_q     <= 9'h000;
         tx_stop_n_q <= 1'b0;
         tx_line_q   <= 1'b1;
      end
      else if (!tx_act)
      begin
         tx_st_q   <= UBF_TX_IDLE;
         tx_line_q <= 1'b1;
      end
      else if (ovs_tick)
      begin
         tx_ph_q <= tx_ph_q + 4'h1;
         case (tx_st_q)
            UBF_TX_IDLE:
               if (txbuf_full_q)
               begin
                  tx_sh_q <= txbuf_q;
                  // top slot carries parity when enabled
                  if (par_en && wlen9)
                     tx_sh_q[8] <= par_of(txbuf_q, 1'b1, par_odd);
                  else if (par_en)
                     tx_sh_q[7] <= par_of(txbuf_q, 1'b0, par_odd);
                  tx_st_q   <= UBF_TX_START;
                  tx_ph_q   <= 4'h0; // start bit gets a full sixteen ticks
                  tx_line_q <= 1'b0;
               end
               else
                  tx_line_q <= 1'b1;
            UBF_TX_START:
               if (tx_ph_q == 4'hF)
               begin
                  tx_st_q   <= UBF_TX_DATA;
                  tx_bit_q  <= 4'h0;
                  tx_line_q <= tx_sh_q[0];
               end
            UBF_TX_DATA:
               if (tx_ph_q == 4'hF)
               begin
                  if (tx_bit_q == nbits - 4'h1)
                  begin
                     tx_st_q     <= UBF_TX_STOP;
                     tx_stop_n_q <= stop2;
                     tx_line_q   <= 1'b1;
                  end
                  else
                  begin
                     tx_bit_q  <= tx_bit_q + 4'h1;
                     tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
                     tx_line_q <= tx_sh_q[1];
                  end
               end
            UBF_TX_STOP:
               if (tx_ph_q == 4'hF)
               begin
                  if (tx_stop_n_q)
                     tx_stop_n_q <= 1'b0;
                  else
                     tx_st_q <= UBF_TX_IDLE;
               end
            default:
               tx_st_q <= UBF_TX_IDLE;
         endcase
      end

   // transmit idle: set when a frame ends or the unit is off
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         transmit_idle_q <= 1'b1;
      else if (!unit_en)
         transmit_idle_q <= 1'b1;
      else if (tx_act && ovs_tick && tx_st_q == UBF_TX_STOP && tx_ph_q == 4'hF
               && !tx_stop_n_q)
         transmit_idle_q <= 1'b1;
      else if (reg_wr && reg_addr == `UBF_OFS_TXDATA)
         transmit_idle_q <= 1'b0;

   // receive sequencer; bit centred by counting eight ticks past the start edge
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         rx_st_q    <= UBF_RX_IDLE;
         rx_ph_q    <= 4'h0;
         rx_bit_q   <= 4'h0;
         rx_sh_q    <= 9'h000;
         rx_noise_q <= 1'b0;
      end
      else if (!rx_act)
         rx_st_q <= UBF_RX_IDLE;
      else if (ovs_tick)
      begin
         rx_ph_q <= rx_ph_q + 4'h1;
         if (rx_ph_q == 4'h9)
            rx_noise_q <= rx_noise_q | noisy;
         case (rx_st_q)
            UBF_RX_IDLE:
               if (!voted)
               begin
                  rx_st_q    <= UBF_RX_START;
                  rx_ph_q    <= 4'h1;
                  rx_noise_q <= 1'b0;
               end
            UBF_RX_START:
               if (rx_ph_q == 4'h9)
               begin
                  if (voted)
                     rx_st_q <= UBF_RX_IDLE; // false start
                  else
                  begin
                     rx_st_q  <= UBF_RX_DATA;
                     rx_bit_q <= 4'h0;
                  end
               end
            UBF_RX_DATA:
               if (rx_ph_q == 4'h9)
               begin
                  rx_sh_q[rx_bit_q] <= voted;
                  if (rx_bit_q == nbits - 4'h1)
                     rx_st_q <= UBF_RX_STOP;
                  else
                     rx_bit_q <= rx_bit_q + 4'h1;
               end
            UBF_RX_STOP:
               if (rx_ph_q == 4'h9)
                  rx_st_q <= UBF_RX_IDLE;
            default:
               rx_st_q <= UBF_RX_IDLE;
         endcase
      end

   assign rx_done    = rx_act && ovs_tick && rx_st_q == UBF_RX_STOP && rx_ph_q == 4'h9;
   assign rx_par_bad = par_en &&
      (par_of(rx_sh_q, wlen9, par_odd) != (wlen9 ? rx_sh_q[8] : rx_sh_q[7]));
   // address detect keeps only words whose top bit is one
   assign rx_keep    = !addr_en || (wlen9 ? rx_sh_q[8] : rx_sh_q[7]);

   // receive buffer and status; set wins over software clear
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         rxbuf_q <= 9'h000;
         receive_available_flag_q  <= 1'b0;
         overrun_error_q  <= 1'b0;
         framing_error_q  <= 1'b0;
         parity_error_q  <= 1'b0;
         nf_q    <= 1'b0;
      end
      else if (!unit_en)
      begin
         receive_available_flag_q <= 1'b0;
         overrun_error_q <= 1'b0;
         framing_error_q <= 1'b0;
         parity_error_q <= 1'b0;
         nf_q   <= 1'b0;
      end
      else if (rx_done && rx_keep)
      begin
         if (receive_available_flag_q && !(reg_rd && reg_addr == `UBF_OFS_RXDATA))
            overrun_error_q <= 1'b1;
         else
         begin
            rxbuf_q <= wlen9 ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
            receive_available_flag_q  <= 1'b1;
            framing_error_q  <= !voted;
            parity_error_q  <= rx_par_bad;
            nf_q    <= rx_noise_q | noisy;
         end
      end
      else if (reg_rd && reg_addr == `UBF_OFS_RXDATA)
      begin
         receive_available_flag_q <= 1'b0;
         overrun_error_q <= 1'b0;
      end

   // receive idle: set while no frame is in progress
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         receive_idle_q <= 1'b1;
      else
         receive_idle_q <= !rx_act || rx_st_q == UBF_RX_IDLE;

   // register read port, data one cycle after the strobe
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == `UBF_OFS_CTRL_A)
            reg_rdata <= {ctrl_a_q[7:2], 1'b0, rxbuf_q[8]};
         else if (reg_addr == `UBF_OFS_CTRL_B)
            reg_rdata <= ctrl_b_q;
         else if (reg_addr == `UBF_OFS_DIV)
            reg_rdata <= div_q;
         else if (reg_addr == `UBF_OFS_STATUS)
            reg_rdata <= {parity_error_q, nf_q, framing_error_q, overrun_error_q, receive_idle_q, receive_available_flag_q, transmit_idle_q,
                          !txbuf_full_q};
         else if (reg_addr == `UBF_OFS_RXDATA)
            reg_rdata <= rxbuf_q[7:0];
         else
            reg_rdata <= 8'h00;
      end
      else
         reg_rdata <= 8'h00;

   // pin ownership: shared pins released when the unit is off
   assign tx_out = tx_line_q;
   assign tx_oe  = tx_act;
   assign rx_sel = rx_act;
endmodule // ubf_serial_port

// File: shared/ubf_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by every design, checker and bench file that needs them
`ifndef UBF_CFG_SVH
`define UBF_CFG_SVH
`define UBF_ADDR_W        3
`define UBF_OFS_CTRL_A    3'h0
`define UBF_OFS_CTRL_B    3'h1
`define UBF_OFS_DIV       3'h2
`define UBF_OFS_STATUS    3'h3
`define UBF_OFS_TXDATA    3'h4
`define UBF_OFS_RXDATA    3'h5
// control a fields
`define UBF_A_EN          7
`define UBF_A_WLEN        6
`define UBF_A_PAREN       5
`define UBF_A_PARODD      4
`define UBF_A_STOP2       3
`define UBF_A_BRK         2
`define UBF_A_TX8         0
// control b fields
`define UBF_B_TRANSMIT_ENABLE        7
`define UBF_B_RECEIVE_ENABLE        6
`define UBF_B_SPEED       5
`define UBF_B_ADDEN       4
// status fields
`define UBF_S_PARITY_ERROR        7
`define UBF_S_NF          6
`define UBF_S_FRAMING_ERROR        5
`define UBF_S_OVERRUN_ERROR        4
`define UBF_S_RECEIVE_IDLE       3
`define UBF_S_RECEIVE_AVAILABLE_FLAG        2
`define UBF_S_TRANSMIT_IDLE       1
`define UBF_S_TRANSMIT_EMPTY_FLAG        0
// reset values: 8 data bits, no parity, one stop bit
`define UBF_CTRL_A_RST    8'h00
`define UBF_CTRL_B_RST    8'h00
`define UBF_DIV_RST       8'h00
// oversampling ticks per bit
`define UBF_OVS_HI        16
`define UBF_OVS_LO        64
`define UBF_OVS_LO_MUL    4
`endif

// File: shared/ubf_pkg.sv
// types shared by the serial port design files
// assumes ubf_cfg.svh is on the include path
package ubf_pkg;
   typedef enum logic [1:0] {
      UBF_TX_IDLE  = 2'b00,
      UBF_TX_START = 2'b01,
      UBF_TX_DATA  = 2'b10,
      UBF_TX_STOP  = 2'b11
   } ubf_tx_state_t;
   typedef enum logic [1:0] {
      UBF_RX_IDLE  = 2'b00,
      UBF_RX_START = 2'b01,
      UBF_RX_DATA  = 2'b10,
      UBF_RX_STOP  = 2'b11
   } ubf_rx_state_t;
endpackage

// File: hw/ubf_baud_gen.sv
// baud rate generator: free running 8-bit timer plus oversample prescaler
// assumes one clock, mclk; clear holds it stopped while the port is off
`timescale 1ns/1ns
`include "ubf_cfg.svh"
module ubf_baud_gen
   import ubf_pkg::*;
#(
   parameter int DIV_W = 8
)(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_b,
   // control
   input  wire logic             clear,
   input  wire logic [DIV_W-1:0] divisor,
   input  wire logic             speed_sel,
   // ticks
   output logic                  ovs_tick,
   output logic                  timer_tick
);
   // refused at elaboration, before any timer logic is built
   if (DIV_W < 1 || DIV_W > 16) $error("ubf_baud_gen: DIV_W out of range");

   logic [DIV_W-1:0] cnt_q;
   logic [1:0]       pre_q;

   // timer counts 0..divisor then reloads; any divisor incl. zero is fine
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         cnt_q <= '0;
      else if (clear || cnt_q >= divisor)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + 1'b1;

   assign timer_tick = !clear && (cnt_q >= divisor);

   // low speed divides each timer tick by four more: 64 vs 16 per bit
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         pre_q <= 2'h0;
      else if (clear)
         pre_q <= 2'h0;
      else if (timer_tick)
         pre_q <= pre_q + 2'h1;

   assign ovs_tick = timer_tick && (speed_sel || pre_q == 2'h3);
endmodule // ubf_baud_gen

// File: hw/ubf_rx_vote.sv
// receive pin recovery: three samples at mid-bit, majority vote
// assumes ovs_tick at sixteen times the bit rate
`timescale 1ns/1ns
`include "ubf_cfg.svh"
module ubf_rx_vote
   import ubf_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // sampling
   input  wire logic ovs_tick,
   input  wire logic rx_pin,
   // result
   output logic      voted,
   output logic      noisy
);
   logic [2:0] hist_q;

   // shift in one sample per oversample tick; idle line is high
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         hist_q <= 3'h7;
      else if (ovs_tick)
         hist_q <= {hist_q[1:0], rx_pin};

   assign voted = (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) |
                  (hist_q[0] & hist_q[2]);
   assign noisy = !(&hist_q) && (|hist_q);
endmodule // ubf_rx_vote

// File: dv/ubf_serial_port_properties.sv
// checker for the serial port: register readback, pin ownership, bit timing
// assumes a bind onto ubf_serial_port, one clock and an async low reset
`timescale 1ns/1ns
`include "ubf_cfg.svh"
module ubf_sp_checker
   import ubf_pkg::*;
#(
   parameter int DIV_W = 8
)(
   // clock and reset
   input wire logic                   mclk,
   input wire logic                   rst_b,
   // register port
   input wire logic [`UBF_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [7:0]             reg_rdata,
   // serial pins
   input wire logic                   tx_out,
   input wire logic                   tx_oe,
   input wire logic                   rx_in,
   input wire logic                   rx_sel
);
   logic [7:2]       ctla_q;
   logic [7:4]       ctlb_q;
   logic [DIV_W-1:0] div_q;
   int               lo_cnt_q;
   logic             lo_ok_q;
   int               per;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // shadow of the control fields; turning the unit off drops enables and break
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         ctla_q <= '0;
         ctlb_q <= '0;
         div_q  <= '0;
      end
      else if (reg_wr && reg_addr == `UBF_OFS_CTRL_A)
      begin
         ctla_q <= {reg_wdata[7:3], reg_wdata[2] & reg_wdata[7]};
         if (!reg_wdata[7])
            ctlb_q[7:6] <= 2'h0;
      end
      else if (reg_wr && reg_addr == `UBF_OFS_CTRL_B)
         ctlb_q <= ctla_q[7] ? reg_wdata[7:4] : {ctlb_q[7:6], reg_wdata[5:4]};
      else if (reg_wr && reg_addr == `UBF_OFS_DIV)
         div_q <= reg_wdata[DIV_W-1:0];
   // one bit in clock cycles; divisor changes mid-frame are not expected
   assign per = 16 * (int'(div_q) + 1) * (ctlb_q[5] ? 1 : 4);
   // length of the present low run on the tx pin, valid only while driven
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         lo_cnt_q <= 0;
         lo_ok_q  <= 1'b1;
      end
      else if (tx_out)
      begin
         lo_cnt_q <= 0;
         lo_ok_q  <= 1'b1;
      end
      else
      begin
         lo_cnt_q <= lo_cnt_q + 1;
         lo_ok_q  <= lo_ok_q & tx_oe;
      end
   chk_rdata_quiet: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data seen outside the answer cycle");
   chk_div_readback: assert property (reg_rd && reg_addr == `UBF_OFS_DIV |=> reg_rdata == div_q)
      else $error("divisor readback differs from last write");
   chk_ctrl_a_kept: assert property (reg_rd && reg_addr == `UBF_OFS_CTRL_A |=> reg_rdata[7:2] == ctla_q)
      else $error("control a fields lost");
   chk_ctrl_b_kept: assert property (reg_rd && reg_addr == `UBF_OFS_CTRL_B |=> reg_rdata[7:4] == ctlb_q)
      else $error("control b fields wrong");
   chk_tx_owner: assert property (tx_oe == (ctla_q[7] && ctlb_q[7]))
      else $error("tx pin ownership wrong");
   chk_rx_owner: assert property (rx_sel == (ctla_q[7] && ctlb_q[6]))
      else $error("rx pin ownership wrong");
   chk_status_off: assert property (reg_rd && reg_addr == `UBF_OFS_STATUS && !ctla_q[7] |=> reg_rdata == 8'h0B)
      else $error("status not at off values");
   chk_idle_high: assert property (!tx_oe && !$past(tx_oe) |-> tx_out)
      else $error("tx pin low while not sending");
   chk_bit_period: assert property (tx_oe && tx_out && !$past(tx_out) && lo_ok_q |-> lo_cnt_q % per == 0)
      else $error("tx low run not a whole number of bits");
   cov_frame_sent: cover property (tx_oe && $rose(tx_out) && lo_ok_q);
   cov_abort: cover property ($fell(tx_oe) && !tx_out);
   cov_status_off: cover property (reg_rd && reg_addr == `UBF_OFS_STATUS && !ctla_q[7]);
endmodule // ubf_sp_checker

// File: dv/ubf_link_partner.sv
// remote serial party: captures frames from the tx pin, sends frames on rx
// assumes the bench sets per, nbits and stop_count_sel before each frame
`timescale 1ns/1ns
module ubf_link_partner (
   // clock
   input  wire logic mclk,
   // device transmit side
   input  wire logic tx_line,
   input  wire logic tx_en,
   // device receive side
   output logic      rx_line
);
   int         per = 32;
   int         nbits = 8;
   int         stop_count_sel = 1;
   int         got_cnt = 0;
   logic [8:0] got_word = '0;
   logic       got_stop = 1'b0;
   initial rx_line = 1'b1;
   // mid-bit capture, lsb first; an aborted frame is not counted
   always @(negedge tx_line)
      if (tx_en)
      begin
         got_word = '0;
         repeat (per / 2) @(posedge mclk);
         for (int i = 0; i < nbits; i++)
         begin
            repeat (per) @(posedge mclk);
            got_word[i] = tx_line;
         end
         got_stop = 1'b1;
         for (int s = 0; s < stop_count_sel; s++)
         begin
            repeat (per) @(posedge mclk);
            got_stop = got_stop & tx_line;
         end
         if (tx_en)
            got_cnt++;
      end
   // start bit, data lsb first, then high stop bits; idle line stays high
   task automatic send(input logic [8:0] w, input int n, input int ns);
      @(posedge mclk);
      rx_line <= 1'b0;
      for (int i = 0; i <= n; i++)
      begin
         repeat (per) @(posedge mclk);
         rx_line <= (i == n) ? 1'b1 : w[i];
      end
      repeat (per * ns) @(posedge mclk);
   endtask
endmodule // ubf_link_partner

// File: dv/ubf_serial_port_bench.sv
// bench for the serial port: register tasks and frame checks via the partner
// assumes design, checker and partner are compiled before this file
`timescale 1ns/1ns
`include "ubf_cfg.svh"
module ubf_serial_port_bench;
   logic                   mclk;
   logic                   rst_b;
   logic [`UBF_ADDR_W-1:0] reg_addr;
   logic [7:0]             reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [7:0]             reg_rdata;
   logic                   tx_out;
   logic                   tx_oe;
   logic                   rx_in;
   logic                   rx_sel;
   logic [7:0]             v;
   int                     bad_count = 0;
   int                     samples_checked = 0;
   int                     cyc = 0;
   int                     per = 32;
   int                     seen;
   ubf_serial_port u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .rx_sel(rx_sel));
   ubf_link_partner u_link (.mclk(mclk), .tx_line(tx_out), .tx_en(tx_oe), .rx_line(rx_in));
   // 100 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, well above the longest expected run
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
      chk(what, {1'b0, e}, {1'b0, v});
   endtask
   task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
      wr(`UBF_OFS_CTRL_A, a);
      wr(`UBF_OFS_CTRL_B, b);
      wr(`UBF_OFS_DIV, d);
      per = 16 * (int'(d) + 1) * (b[5] ? 1 : 4);
      u_link.per = per;
   endtask
   // with two stop_count_sel a second word is queued so a short stop shows up
   task automatic tx_frame(input logic [7:0] d, input logic [8:0] e, input int n, input int s);
      u_link.nbits = n;
      u_link.stop_count_sel = s;
      seen = u_link.got_cnt;
      wr(`UBF_OFS_TXDATA, d);
      if (s == 2)
      begin
         repeat (per) @(posedge mclk);
         wr(`UBF_OFS_TXDATA, d);
      end
      for (int i = 0; i < 16 * per && u_link.got_cnt == seen; i++)
         @(posedge mclk);
      chk("tx count", seen[8:0] + 9'h001, u_link.got_cnt[8:0]);
      chk("tx frame", e, u_link.got_word);
      chk("tx stop", 9'h001, {8'h00, u_link.got_stop});
   endtask
   initial
   begin
      rst_b     = 1'b0;
      reg_addr  = '0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      expect_reg("ctrl_a", `UBF_OFS_CTRL_A, 8'h00);
      expect_reg("status", `UBF_OFS_STATUS, 8'h0B);
      expect_reg("unmapped", 3'h7, 8'h00);
      wr(`UBF_OFS_DIV, 8'hFF);
      expect_reg("divisor", `UBF_OFS_DIV, 8'hFF);
      cfg(8'h80, 8'hE0, 8'h01);
      tx_frame(8'hA5, 9'h0A5, 8, 1);
      for (int p = 0; p < 2; p++)
      begin
         wr(`UBF_OFS_CTRL_A, 8'hA0 | {3'h0, p[0], 4'h0});
         tx_frame(8'h35, {1'b0, ^7'h35 ^ p[0], 7'h35}, 8, 1);
      end
      wr(`UBF_OFS_CTRL_A, 8'hC9);
      tx_frame(8'h3C, 9'h13C, 9, 2);
      repeat (14 * per) @(posedge mclk);
      cfg(8'h80, 8'hC0, 8'h00);
      tx_frame(8'h5A, 9'h05A, 8, 1);
      cfg(8'h80, 8'hE0, 8'h01);
      u_link.send(9'h096, 8, 1);
      expect_reg("status", `UBF_OFS_STATUS, 8'h0F);
      expect_reg("rx data", `UBF_OFS_RXDATA, 8'h96);
      wr(`UBF_OFS_CTRL_A, 8'h88);
      u_link.send(9'h041, 8, 1);
      u_link.send(9'h000, 8, 1);
      expect_reg("status", `UBF_OFS_STATUS, 8'h1F);
      expect_reg("rx data", `UBF_OFS_RXDATA, 8'h41);
      cfg(8'h80, 8'hF0, 8'h01);
      u_link.send(9'h012, 8, 1);
      expect_reg("status", `UBF_OFS_STATUS, 8'h0B);
      u_link.send(9'h085, 8, 1);
      expect_reg("rx data", `UBF_OFS_RXDATA, 8'h85);
      cfg(8'hA0, 8'hE0, 8'h01);
      u_link.send(9'h043, 8, 1);
      expect_reg("status", `UBF_OFS_STATUS, 8'h8F);
      wr(`UBF_OFS_CTRL_A, 8'h88);
      seen = u_link.got_cnt;
      wr(`UBF_OFS_TXDATA, 8'h00);
      repeat (3 * per) @(posedge mclk);
      wr(`UBF_OFS_CTRL_A, 8'h08);
      // the line is registered: it returns high on the edge after the write lands
      @(posedge mclk);
      #1;
      chk("tx pin", 9'h003, {7'h00, tx_out, ~tx_oe});
      expect_reg("status", `UBF_OFS_STATUS, 8'h0B);
      expect_reg("ctrl_a", `UBF_OFS_CTRL_A, 8'h08);
      expect_reg("ctrl_b", `UBF_OFS_CTRL_B, 8'h20);
      expect_reg("divisor", `UBF_OFS_DIV, 8'h01);
      repeat (14 * per) @(posedge mclk);
      chk("aborted count", seen[8:0], u_link.got_cnt[8:0]);
      wr(`UBF_OFS_CTRL_A, 8'h88);
      wr(`UBF_OFS_CTRL_B, 8'hE0);
      tx_frame(8'hC3, 9'h0C3, 8, 2);
      repeat (14 * per) @(posedge mclk);
      close_out();
   end
endmodule // ubf_serial_port_bench
bind ubf_serial_port ubf_sp_checker #(.DIV_W(DIV_W)) u_chk (.mclk(mclk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .rx_sel(rx_sel));
